// ===== rtl/spi_serial_port.sv
// Serial port in SPI mode: register slave, master clock engine and slave shifter
`timescale 1ns/1ps
`include "spi_port_cfg.svh"

module spi_serial_port #(
    parameter int ADDR_W = 3
) (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire logic              timer_two_tick_i,
    input  wire logic              sleep_i,
    input  wire logic              sck_i,
    output logic                   sck_o,
    output logic                   sck_oe_n_o,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   sdo_oe_n_o,
    input  wire logic              ss_n_i,
    output logic                   port_interrupt_flag_o,
    output logic                   wake_o
);
    import spi_port_pkg::*;

    spi_port_pkg::state_t state_r;
    spi_port_pkg::state_t state_nxt;

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    logic       is_master;
    logic       is_slave;
    logic       ss_ctl;
    logic       serial_rst;
    logic       busy;
    logic [5:0] half_len;

    always_comb
    begin
        is_master = (state_r.mode == `MODE_M_DIV4) || (state_r.mode == `MODE_M_DIV16) ||
                    (state_r.mode == `MODE_M_DIV64) || (state_r.mode == `MODE_M_TIMER_TWO) ||
                    (state_r.mode == `MODE_M_DIV8);
        is_slave  = (state_r.mode == `MODE_S_SSCTL) || (state_r.mode == `MODE_S_NOSS);
        ss_ctl    = (state_r.mode == `MODE_S_SSCTL);
        // Select high (slave with select control only), enable low or peripheral disable forces the shifter back to bit zero
        serial_rst = !state_r.en || state_r.pmd || (is_slave && ss_ctl && state_r.ss_s);
        busy       = (state_r.st == ST_RUN) || (is_slave && state_r.bitcnt != 4'h0) ||
                     (state_r.cmp_p != 2'b00);
        unique case (state_r.mode)
            `MODE_M_DIV16: half_len = `HALF_DIV16;
            `MODE_M_DIV64: half_len = `HALF_DIV64;
            `MODE_M_DIV8:  half_len = `HALF_DIV8;
            default:       half_len = `HALF_DIV4;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    logic       tick;
    logic       leading;
    logic       out_edge;
    logic       sample;
    logic       done;
    logic       complete;
    logic [7:0] rx_new;
    logic       buf_wr;

    always_comb
    begin
        state_nxt = state_r;
        tick      = 1'b0;
        leading   = 1'b0;
        out_edge  = 1'b0;
        sample    = 1'b0;
        done      = 1'b0;
        complete  = 1'b0;
        rx_new    = {state_r.rx_sh[6:0], state_r.sdi_s};
        buf_wr    = wr_i && (addr_i == `OFS_DATA_BUFFER);

        // Pins cross into this domain through two flops each
        state_nxt.sck_m = sck_i;
        state_nxt.sck_s = state_r.sck_m;
        state_nxt.sdi_m = sdi_i;
        state_nxt.sdi_s = state_r.sdi_m;
        state_nxt.ss_m  = ss_n_i;
        state_nxt.ss_s  = state_r.ss_m;
        state_nxt.slp_m = sleep_i;
        state_nxt.slp_s = state_r.slp_m;
        state_nxt.sck_prev = state_r.sck_s;

        // Register writes
        if (wr_i)
        begin
            unique case (addr_i)
                `OFS_DATA_BUFFER:
                begin
                    if (busy)
                    begin
                        state_nxt.write_collision_flag = 1'b1;
                    end
                    else
                    begin
                        state_nxt.data_buf = wdata_i;
                        state_nxt.tx_sh    = wdata_i;
                        if (state_r.cke)
                        begin
                            // MSB shown before the first clock edge
                            state_nxt.sdo   = wdata_i[7];
                            state_nxt.tx_sh = {wdata_i[6:0], 1'b0};
                        end
                        if (is_master && !serial_rst)
                        begin
                            state_nxt.st   = ST_RUN;
                            state_nxt.hcnt = 5'h00;
                            state_nxt.div  = 6'h00;
                        end
                    end
                end
                `OFS_CONTROL_ONE:
                begin
                    state_nxt.write_collision_flag = wdata_i[`CTL_WRITE_COLLISION_FLAG_BIT];
                    state_nxt.ovf  = wdata_i[`CTL_OVF_BIT];
                    state_nxt.en   = wdata_i[`CTL_EN_BIT];
                    state_nxt.clock_polarity  = wdata_i[`CTL_CKP_BIT];
                    state_nxt.mode = wdata_i[3:0];
                end
                `OFS_STATUS:
                begin
                    state_nxt.input_sample_phase = wdata_i[`STS_SMP_BIT];
                    state_nxt.cke = wdata_i[`STS_CKE_BIT];
                end
                `OFS_OPEN_DRAIN: state_nxt.od  = wdata_i[`OD_PORT_BIT];
                `OFS_PERIPH_DIS: state_nxt.pmd = wdata_i[`PMD_PORT_BIT];
                `OFS_INTR_CTRL:
                begin
                    state_nxt.ie   = wdata_i[`INT_EN_BIT];
                    state_nxt.flag = wdata_i[`INT_FLAG_BIT];
                end
                default: ;
            endcase
        end

        // Register reads, data valid only in the following cycle
        state_nxt.rdata = 8'h00;
        if (rd_i)
        begin
            unique case (addr_i)
                `OFS_DATA_BUFFER:
                begin
                    state_nxt.rdata = state_r.data_buf;
                    state_nxt.bf    = 1'b0;
                end
                `OFS_CONTROL_ONE: state_nxt.rdata = {state_r.write_collision_flag, state_r.ovf, state_r.en, state_r.clock_polarity, state_r.mode};
                `OFS_STATUS:      state_nxt.rdata = {state_r.input_sample_phase, state_r.cke, 5'h00, state_r.bf};
                `OFS_OPEN_DRAIN:  state_nxt.rdata = {state_r.od, 7'h00};
                `OFS_PERIPH_DIS:  state_nxt.rdata = {7'h00, state_r.pmd};
                `OFS_INTR_CTRL:   state_nxt.rdata = {state_r.flag, 6'h00, state_r.ie};
                default:          state_nxt.rdata = 8'h00;
            endcase
        end

        // Pin sync delays data-in by two clocks, so master samples and the finish lag as much
        state_nxt.smp_p = {state_r.smp_p[0], 1'b0};
        state_nxt.cmp_p = {state_r.cmp_p[0], 1'b0};
        if (state_r.smp_p[1])
        begin
            state_nxt.rx_sh = rx_new;
        end
        if (state_r.cmp_p[1])
        begin
            complete = 1'b1;
        end

        // Master engine: sixteen half periods per byte, frozen while asleep
        if (is_master && state_r.st == ST_RUN && !state_r.slp_s)
        begin
            if (state_r.mode == `MODE_M_TIMER_TWO)
            begin
                tick = timer_two_tick_i;
            end
            else
            begin
                tick          = (state_r.div == half_len - 6'h01);
                state_nxt.div = tick ? 6'h00 : state_r.div + 6'h01;
            end
            if (tick)
            begin
                leading  = !state_r.hcnt[0];
                out_edge = state_r.cke ? !leading : leading;
                if (state_r.hcnt <= `BYTE_HALVES)
                begin
                    state_nxt.sck = !state_r.sck;
                end
                // Sample mid bit, or at the bit's end when the sample bit is set
                if (state_r.input_sample_phase)
                begin
                    sample = state_r.cke ? !leading
                                         : (leading && state_r.hcnt != 5'h00) || state_r.hcnt == `BYTE_HALVES_EXT;
                end
                else
                begin
                    sample = !out_edge && state_r.hcnt <= `BYTE_HALVES;
                end
                if (out_edge && state_r.hcnt <= `BYTE_HALVES)
                begin
                    state_nxt.sdo   = state_r.tx_sh[7];
                    state_nxt.tx_sh = {state_r.tx_sh[6:0], 1'b0};
                end
                // Data-out direction plays no part: data-in is sampled regardless
                if (sample)
                begin
                    state_nxt.smp_p[0] = 1'b1;
                end
                done = (state_r.cke || !state_r.input_sample_phase) ? state_r.hcnt == `BYTE_HALVES
                                                     : state_r.hcnt == `BYTE_HALVES_EXT;
                state_nxt.hcnt = state_r.hcnt + 5'h01;
                if (done)
                begin
                    state_nxt.st       = ST_IDLE;
                    state_nxt.cmp_p[0] = 1'b1;
                end
            end
        end
        else if (state_r.st != ST_RUN)
        begin
            state_nxt.sck = state_r.clock_polarity;
        end

        // Slave shifter: runs on external clock edges, sleep or not
        if (is_slave && !serial_rst && state_r.sck_s != state_r.sck_prev)
        begin
            leading  = (state_r.sck_prev == state_r.clock_polarity);
            out_edge = state_r.cke ? !leading : leading;
            if (out_edge)
            begin
                state_nxt.sdo   = state_r.tx_sh[7];
                state_nxt.tx_sh = {state_r.tx_sh[6:0], 1'b0};
            end
            else
            begin
                state_nxt.rx_sh  = rx_new;
                state_nxt.bitcnt = state_r.bitcnt + 4'h1;
                if (state_r.bitcnt == `LAST_BIT)
                begin
                    state_nxt.bitcnt = 4'h0;
                    complete         = 1'b1;
                end
            end
        end

        // A finished byte lands in the buffer unless a slave finds it still full; hardware sets win over clears
        if (complete)
        begin
            state_nxt.flag = 1'b1;
            if (is_slave && state_r.bf)
            begin
                state_nxt.ovf = 1'b1;
            end
            else
            begin
                state_nxt.data_buf = state_nxt.rx_sh;
                state_nxt.bf       = 1'b1;
            end
        end

        // Serial reset abandons the byte in flight
        if (serial_rst)
        begin
            state_nxt.bitcnt = 4'h0;
            state_nxt.st     = ST_IDLE;
            state_nxt.hcnt   = 5'h00;
            state_nxt.div    = 6'h00;
            state_nxt.sck    = state_r.clock_polarity;
            state_nxt.smp_p  = 2'b00;
            state_nxt.cmp_p  = 2'b00;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    logic drive_sck;
    logic drive_sdo;

    // Open-drain only ever pulls low; a high level comes from the pull-up
    always_comb
    begin
        drive_sck  = state_r.en && !state_r.pmd && is_master;
        drive_sdo  = state_r.en && !state_r.pmd &&
                     (is_master || (is_slave && !(ss_ctl && state_r.ss_s)));
        sck_o      = state_r.od ? 1'b0 : state_r.sck;
        sck_oe_n_o = !(drive_sck && !(state_r.od && state_r.sck));
        sdo_o      = state_r.od ? 1'b0 : state_r.sdo;
        sdo_oe_n_o = !(drive_sdo && !(state_r.od && state_r.sdo));
    end

    assign rdata_o               = state_r.rdata;
    assign port_interrupt_flag_o = state_r.flag;
    assign wake_o                = state_r.flag && state_r.ie;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_od_low;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (state_r.od && !sdo_oe_n_o) |-> !sdo_o && (sck_oe_n_o || !sck_o);
    endproperty
    a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");

    property p_disabled_float;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !state_r.en |-> sdo_oe_n_o && sck_oe_n_o;
    endproperty
    a_disabled_float: assert property (p_disabled_float) else $error("pin driven while disabled");

    property p_write_starts;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (buf_wr && is_master && !busy && !serial_rst) |=> state_r.st == ST_RUN && state_r.hcnt == 5'h00;
    endproperty
    a_write_starts: assert property (p_write_starts) else $error("buffer write did not start transfer");

    property p_msb_first;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (buf_wr && !busy && state_r.cke) |=> state_r.sdo == $past(wdata_i[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB");

    property p_idle_level;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (state_r.st == ST_IDLE && $past(state_r.st) == ST_IDLE && $stable(state_r.clock_polarity)) |-> state_r.sck == state_r.clock_polarity;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

    property p_done_flag;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        complete |=> state_r.flag && (state_r.bf || state_r.ovf);
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("completion did not raise the flag");

    property p_ss_release;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (is_slave && ss_ctl && state_r.ss_s) |-> sdo_oe_n_o ##1 state_r.bitcnt == 4'h0;
    endproperty
    a_ss_release: assert property (p_ss_release) else $error("select high but still driving");

    property p_disable_clears;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!state_r.en) |=> state_r.bitcnt == 4'h0 && state_r.st == ST_IDLE;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("bit counter kept on disable");

    property p_sleep_freeze;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (is_master && state_r.st == ST_RUN && state_r.slp_s && !wr_i && state_r.en && !state_r.pmd)
            |=> $stable(state_r.hcnt) && $stable(state_r.sck);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("master moved during sleep");

    property p_wake;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        complete && state_r.ie && !wr_i |=> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("completion did not wake");

    property p_collision;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (buf_wr && busy) |=> state_r.write_collision_flag;
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged");

endmodule : spi_serial_port

// ===== rtl/spi_port_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_DATA_BUFFER   3'h0
`define OFS_CONTROL_ONE   3'h1
`define OFS_STATUS        3'h2
`define OFS_OPEN_DRAIN    3'h3
`define OFS_PERIPH_DIS    3'h4
`define OFS_INTR_CTRL     3'h5

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_WRITE_COLLISION_FLAG_BIT      7
`define CTL_OVF_BIT       6
`define CTL_EN_BIT        5
`define CTL_CKP_BIT       4
`define STS_SMP_BIT       7
`define STS_CKE_BIT       6
`define STS_BF_BIT        0
`define OD_PORT_BIT       7
`define PMD_PORT_BIT      0
`define INT_FLAG_BIT      7
`define INT_EN_BIT        0

// ----------------------------------------------------------------------------
// Mode codes and reset value
// ----------------------------------------------------------------------------
`define MODE_M_DIV4       4'h0
`define MODE_M_DIV16      4'h1
`define MODE_M_DIV64      4'h2
`define MODE_M_TIMER_TWO       4'h3
`define MODE_S_SSCTL      4'h4
`define MODE_S_NOSS       4'h5
`define MODE_M_DIV8       4'ha
`define REG_RESET         8'h00

// ----------------------------------------------------------------------------
// Half bit periods in system clocks (bit period = clock / 4, 8, 16, 64)
// ----------------------------------------------------------------------------
`define HALF_DIV4         6'h02
`define HALF_DIV8         6'h04
`define HALF_DIV16        6'h08
`define HALF_DIV64        6'h20
`define BYTE_HALVES       5'h0f
`define BYTE_HALVES_EXT   5'h10
`define LAST_BIT          4'h7

`endif

// ===== rtl/spi_port_pkg.sv
// Types of the serial port: engine states and the packed state record
package spi_port_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } run_state_t;

    typedef struct packed {
        logic [7:0] data_buf;
        logic       write_collision_flag;
        logic       ovf;
        logic       en;
        logic       clock_polarity;
        logic [3:0] mode;
        logic       input_sample_phase;
        logic       cke;
        logic       bf;
        logic       od;
        logic       pmd;
        logic       ie;
        logic       flag;
        run_state_t st;
        logic [4:0] hcnt;
        logic [5:0] div;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [3:0] bitcnt;
        logic       sck;
        logic       sdo;
        logic       sck_prev;
        logic       sck_m;
        logic       sck_s;
        logic       sdi_m;
        logic       sdi_s;
        logic       ss_m;
        logic       ss_s;
        logic       slp_m;
        logic       slp_s;
        logic [7:0] rdata;
        logic [1:0] smp_p;
        logic [1:0] cmp_p;
    } state_t;

endpackage : spi_port_pkg

// ===== tb/spi_slave_model.sv
// Behavioural SPI slave in mode 0,0 standing at the far end of the master tests
`timescale 1ns/1ps
module spi_slave_model (
    input  wire logic       sck_i,
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    input  wire logic [7:0] tx_byte_i,
    output logic            miso_o,
    output logic [7:0]      rx_byte_o
);
    logic [7:0] sh_r = 8'h00;
    initial
    begin
        miso_o    = 1'b0;
        rx_byte_o = 8'h00;
    end
    // First bit stands before any clock edge of the byte
    always @(negedge ss_n_i) {miso_o, sh_r} = {tx_byte_i, 1'b0};
    // Sample on the rising edge, shift on the falling one, same idle level as the master
    always @(posedge sck_i) if (!ss_n_i) rx_byte_o = {rx_byte_o[6:0], mosi_i};
    always @(negedge sck_i) if (!ss_n_i) {miso_o, sh_r} = {sh_r, 1'b0};
    // Released line: deselection inverts the data-out value instead of clearing it
    always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule : spi_slave_model

// ===== tb/spi_serial_port_tb.sv
// Self-checking bench of the serial port: registers, master and slave transfers
`timescale 1ns/1ps
`include "spi_port_cfg.svh"
module spi_serial_port_tb;
    import spi_port_pkg::*;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00, tx_byte = 8'h00, rdata_o, rx_byte, d;
    logic       sys_clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, tick = 1'b0;
    logic       sleep_i = 1'b0, sck_drv = 1'b0, sdi_drv = 1'b0, ss_n_i = 1'b1, slv = 1'b0;
    logic       sck_o, sck_oe_n_o, sdo_o, sdo_oe_n_o, miso, flag, wake;
    int         failures = 0, samples_checked = 0, cycles = 0, cyc;
    // Pull-up on the data line; a released clock line follows sck_drv
    wire        sck_pin = sck_oe_n_o ? sck_drv : sck_o;
    wire        sdo_pin = sdo_oe_n_o ? 1'b1 : sdo_o;
    spi_serial_port uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_two_tick_i(tick), .sleep_i(sleep_i),
        .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .sdi_i(slv ? sdi_drv : miso),
        .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o), .ss_n_i(ss_n_i), .port_interrupt_flag_o(flag), .wake_o(wake));
    spi_slave_model far (.sck_i(sck_pin), .ss_n_i(ss_n_i), .mosi_i(sdo_pin), .tx_byte_i(tx_byte),
        .miso_o(miso), .rx_byte_o(rx_byte));
    initial
    begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // Timer tick every third cycle, and the hang limit
    always @(posedge sys_clk_i)
    begin
        tick   <= (cycles % 3 == 0);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    // ----------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 chk(n, e, rdata_o);
    endtask : rchk
    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // One master byte; h is the half bit period in clocks, sl an optional sleep length
    task automatic xfer(input logic [3:0] m, input int h, input int sl);
        ss_n_i  <= 1'b1;
        tx_byte <= 8'h3c ^ {4'h0, m};
        wr(`OFS_CONTROL_ONE, {4'h2, m});
        ss_n_i  <= 1'b0;
        wr(`OFS_DATA_BUFFER, 8'hc3 ^ {m, 4'h0});
        wr(`OFS_DATA_BUFFER, 8'hff);
        cyc = 1;
        if (sl > 0)
        begin
            repeat (8) @(posedge sys_clk_i);
            sleep_i <= 1'b1;
            repeat (sl) @(posedge sys_clk_i);
            #1 chk("frozen flag", 8'h00, {7'h0, flag});
            sleep_i <= 1'b0;
            cyc = sl + 9;
        end
        while (flag !== 1'b1 && cyc < 3000)
        begin
            @(posedge sys_clk_i);
            #1 cyc++;
        end
        chk("duration", 8'h01, {7'h0, cyc >= 16 * h + sl - 3 && cyc <= 17 * h + sl + 4});
        chk("wake", 8'h01, {7'h0, wake});
        rchk("status full", `OFS_STATUS, 8'h41);
        rchk("received", `OFS_DATA_BUFFER, 8'h3c ^ {4'h0, m});
        chk("sent", 8'hc3 ^ {m, 4'h0}, rx_byte);
        rchk("status read", `OFS_STATUS, 8'h40);
        rchk("collision", `OFS_CONTROL_ONE, {4'ha, m});
        wr(`OFS_INTR_CTRL, 8'h01);
        @(posedge sys_clk_i);
        #1 chk("flag clear", 8'h00, {7'h0, flag});
    endtask : xfer
    // Slave byte driven from here as master, sampled on the trailing edge
    task automatic sbits(input logic [7:0] v, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            repeat (4) @(posedge sys_clk_i);
            sck_drv <= 1'b1;
            // Data changes on the leading edge and holds across the sampling edge
            sdi_drv <= v[i];
            repeat (4) @(posedge sys_clk_i);
            sck_drv <= 1'b0;
            d[i] = sdo_pin;
        end
    endtask : sbits
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        for (int a = 0; a < 8; a++)
            rchk("reset value", a[2:0], 8'h00);
        chk("pins released", 8'h03, {6'h0, sck_oe_n_o, sdo_oe_n_o});
        wr(`OFS_CONTROL_ONE, 8'h30);
        @(posedge sys_clk_i);
        #1 chk("idle high", 8'h01, {6'h0, sck_oe_n_o, sck_pin});
        wr(`OFS_OPEN_DRAIN, 8'h80);
        @(posedge sys_clk_i);
        #1 chk("open drain", 8'h02, {6'h0, sck_oe_n_o, sck_o});
        wr(`OFS_OPEN_DRAIN, 8'h00);
        wr(`OFS_CONTROL_ONE, 8'h00);
        wr(`OFS_STATUS, 8'h40);
        wr(`OFS_INTR_CTRL, 8'h01);
        xfer(`MODE_M_DIV4, 2, 0);
        xfer(`MODE_M_DIV16, 8, 0);
        xfer(`MODE_M_DIV64, 32, 0);
        xfer(`MODE_M_TIMER_TWO, 3, 0);
        xfer(`MODE_M_DIV8, 4, 0);
        xfer(`MODE_M_DIV16, 8, 200);
        slv <= 1'b1;
        ss_n_i <= 1'b0;
        wr(`OFS_STATUS, 8'h00);
        wr(`OFS_CONTROL_ONE, 8'h24);
        sbits(8'hff, 3);
        #1 chk("driven", 8'h00, {7'h0, sdo_oe_n_o});
        ss_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1 chk("mid byte release", 8'h01, {7'h0, sdo_oe_n_o});
        ss_n_i <= 1'b0;
        wr(`OFS_DATA_BUFFER, 8'h96);
        sleep_i <= 1'b1;
        sbits(8'h3c, 8);
        repeat (6) @(posedge sys_clk_i);
        #1 chk("slave flag", 8'h01, {7'h0, flag});
        sleep_i <= 1'b0;
        chk("slave sent", 8'h96, d);
        rchk("slave byte", `OFS_DATA_BUFFER, 8'h3c);
        // Slave without select control keeps driving although select is high
        ss_n_i <= 1'b1;
        wr(`OFS_CONTROL_ONE, 8'h25);
        #1 chk("no select drives", 8'h00, {7'h0, sdo_oe_n_o});
        wr(`OFS_PERIPH_DIS, 8'h01);
        #1 chk("module off", 8'h03, {6'h0, sck_oe_n_o, sdo_oe_n_o});
        wrap_up();
    end
endmodule : spi_serial_port_tb
